// *** src/hbfm_pkg.sv ***
// Package of constants for the half-bridge fault manager.
// Assumes a single 125 MHz clock and an AHB-Lite register port.
// ============================================================
// Overview of operation
// - Overcurrent filter expiry latches switch off, flags
// - Overcurrent also sets global load fault bit 6
// - Tripped switch stays off while bit set
// - Enable bits stay set during fault shutdown
// - Open load latches bit, outputs unchanged
// - Open-load bits in separate three registers
// - Overheat warning latches bit 1 only
// - Overheat shutdown latches bit 2, outputs off
// - Undervoltage latches bit 5, outputs off
// - Overvoltage latches bit 4, outputs off
// - Supply faults self-recover, bits stay latched
// - Shorts caught by overcurrent shutdown path
// - Dead time between high and low switches
// - Open load needs low current for filter
package hbfm_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_BRIDGES = 10;
  localparam int CNT_W       = 16;

  // ==========================================================
  // Register indices (byte address = 4 * index)
  localparam logic [3:0] IDX_GLOBAL   = 4'h0;  // global_status_reg
  localparam logic [3:0] IDX_OC_FIRST = 4'h2;  // overcurrent 2..4
  localparam logic [3:0] IDX_OL_FIRST = 4'h5;  // open load 5..7
  localparam logic [3:0] IDX_ENABLE   = 4'h8;  // bridge_activation_ctrl
  localparam logic [3:0] IDX_LIVE     = 4'h9;  // live output state
  localparam int         BRIDGES_PER_REG = 4;

  // ==========================================================
  // Global status bit positions
  localparam int BIT_WARN   = 1;  // overheat_warning
  localparam int BIT_TSD    = 2;  // overheat_shutdown
  localparam int BIT_OV     = 4;  // supply_over_volt
  localparam int BIT_UV     = 5;  // supply_under_volt
  localparam int BIT_LOAD   = 6;  // global_load_fault

  // ==========================================================
  // Reset values
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // ==========================================================
  // Timing: times in ns, counts derived at 125 MHz
  localparam int CLK_PERIOD_NS        = 8;
  localparam int OC_FILTER_NS         = 10000;  // overcurrent_filter_time
  localparam int OL_FILTER_NS         = 20000;  // open_load_filter_time
  localparam int DEAD_HL_NS           = 4000;   // dead_time_high_low
  localparam int DEAD_LH_NS           = 4000;   // dead_time_low_high
  localparam int OC_FILTER_CYC =
    (OC_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OL_FILTER_CYC =
    (OL_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_HL_CYC =
    (DEAD_HL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEAD_LH_CYC =
    (DEAD_LH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================
  // Half-bridge drive state
  typedef enum logic [2:0] {
    HBFM_OFF,
    HBFM_HIGH_ON,
    HBFM_LOW_ON,
    HBFM_DEAD_TO_LOW,
    HBFM_DEAD_TO_HIGH
  } hbfm_drive_t;

endpackage

// *** src/hbfm_leg_if.sv ***
// Interface carrying one half-bridge's controls and results.
// Assumes the fault manager top drives requests and reads results.
`timescale 1ns/10ps
interface hbfm_leg_if;
  // Requests from the top
  logic hi_req;     // High side wanted and allowed
  logic lo_req;     // Low side wanted and allowed
  logic hi_meas;    // High side current above its limit
  logic lo_meas;    // Low side current above its limit
  logic hi_low_i;   // High side current below open-load level
  logic lo_low_i;   // Low side current below open-load level
  // Results to the top
  logic hi_drive;   // High gate drive
  logic lo_drive;   // Low gate drive
  logic hi_oc;      // High overcurrent filter expired, pulse
  logic lo_oc;      // Low overcurrent filter expired, pulse
  logic hi_ol;      // High open-load filter expired, pulse
  logic lo_ol;      // Low open-load filter expired, pulse

  modport top (output hi_req, lo_req, hi_meas, lo_meas, hi_low_i,
               lo_low_i, input hi_drive, lo_drive, hi_oc, lo_oc,
               hi_ol, lo_ol);
  modport leg (input hi_req, lo_req, hi_meas, lo_meas, hi_low_i,
               lo_low_i, output hi_drive, lo_drive, hi_oc, lo_oc,
               hi_ol, lo_ol);
endinterface

// *** src/hbfm_leg.sv ***
// One half-bridge: dead time sequencing and fault filters.
// Assumes synchronous inputs and a shared clock enable.
`timescale 1ns/10ps
module hbfm_leg (
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_ce,
  // Bridge signals
  hbfm_leg_if.leg   leg
);

  // ==========================================================
  // Drive sequencer
  hbfm_pkg::hbfm_drive_t state_q;  // Present drive state
  hbfm_pkg::hbfm_drive_t state_d;  // Next drive state
  logic [15:0] dead_q;             // Dead time counter
  logic [15:0] dead_d;
  logic        dead_done;          // Dead time elapsed

  assign dead_done = (dead_q == 16'h0000);

  // Next state: never both sides, gap on every swap
  always_comb begin
    state_d = state_q;
    dead_d  = (dead_q != 16'h0000) ? dead_q - 16'h0001 : dead_q;
    case (state_q)
      hbfm_pkg::HBFM_OFF: begin
        if (leg.hi_req && !leg.lo_req) begin
          state_d = hbfm_pkg::HBFM_DEAD_TO_HIGH;
          dead_d  = 16'(hbfm_pkg::DEAD_LH_CYC);
        end else if (leg.lo_req && !leg.hi_req) begin
          state_d = hbfm_pkg::HBFM_DEAD_TO_LOW;
          dead_d  = 16'(hbfm_pkg::DEAD_HL_CYC);
        end
      end
      hbfm_pkg::HBFM_HIGH_ON: begin
        if (!leg.hi_req || leg.lo_req) begin
          state_d = hbfm_pkg::HBFM_OFF;
        end
      end
      hbfm_pkg::HBFM_LOW_ON: begin
        if (!leg.lo_req || leg.hi_req) begin
          state_d = hbfm_pkg::HBFM_OFF;
        end
      end
      hbfm_pkg::HBFM_DEAD_TO_HIGH: begin
        if (!leg.hi_req || leg.lo_req) begin
          state_d = hbfm_pkg::HBFM_OFF;
        end else if (dead_done) begin
          state_d = hbfm_pkg::HBFM_HIGH_ON;
        end
      end
      default: begin
        if (!leg.lo_req || leg.hi_req) begin
          state_d = hbfm_pkg::HBFM_OFF;
        end else if (dead_done) begin
          state_d = hbfm_pkg::HBFM_LOW_ON;
        end
      end
    endcase
  end

  // Drive state register
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      state_q <= hbfm_pkg::HBFM_OFF;
      dead_q  <= 16'h0000;
    end else if (i_ce) begin
      state_q <= state_d;
      dead_q  <= dead_d;
    end
  end

  assign leg.hi_drive = (state_q == hbfm_pkg::HBFM_HIGH_ON);
  assign leg.lo_drive = (state_q == hbfm_pkg::HBFM_LOW_ON);

  // ==========================================================
  // Fault filters: 0 high oc, 1 low oc, 2 high ol, 3 low ol
  logic [3:0] cond;    // Condition present while switch on
  logic [3:0] expire;  // Filter expired this cycle
  assign cond[0] = leg.hi_drive && leg.hi_meas;
  assign cond[1] = leg.lo_drive && leg.lo_meas;
  assign cond[2] = leg.hi_drive && leg.hi_low_i;
  assign cond[3] = leg.lo_drive && leg.lo_low_i;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_filt
      localparam int LIM = (g < 2) ? hbfm_pkg::OC_FILTER_CYC
                                   : hbfm_pkg::OL_FILTER_CYC;
      logic [15:0] cnt_q;  // Continuous-condition counter
      // Count while condition holds, restart when it drops
      always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
          cnt_q <= 16'h0000;
        end else if (i_ce) begin
          if (!cond[g] || expire[g]) begin
            cnt_q <= 16'h0000;
          end else begin
            cnt_q <= cnt_q + 16'h0001;
          end
        end
      end
      assign expire[g] = i_ce && cond[g] &&
                         (cnt_q == 16'(LIM - 1));
    end
  endgenerate

  assign leg.hi_oc = expire[0];
  assign leg.lo_oc = expire[1];
  assign leg.hi_ol = expire[2];
  assign leg.lo_ol = expire[3];

endmodule

// *** src/hbfm_top.sv ***
// Fault manager top: status latches, gating and AHB-Lite slave.
// Assumes analog comparators deliver synchronous level inputs.
`timescale 1ns/10ps
module hbfm_top (
  // Clock, reset, enable
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_ce,
  // Analog monitor levels: currents one bit per bridge, then single global flags
  input  wire logic [9:0]  i_high_over_i,
  input  wire logic [9:0]  i_low_over_i,
  input  wire logic [9:0]  i_high_under_i,
  input  wire logic [9:0]  i_low_under_i,
  input  wire logic        i_overheat_warn,
  input  wire logic        i_overheat_trip,
  input  wire logic        i_supply_under,
  input  wire logic        i_supply_over,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // Gate drives
  output logic      [9:0]  o_high_gate,
  output logic      [9:0]  o_low_gate
);

  // ==========================================================
  // Register state
  logic [9:0] high_switch_enable_q;  // Enable bits, host owned
  logic [9:0] low_switch_enable_q;
  logic [9:0] high_switch_overcurrent_q;
  logic [9:0] low_switch_overcurrent_q;
  logic [9:0] high_switch_open_load_q;
  logic [9:0] low_switch_open_load_q;
  logic       warn_q;                // overheat_warning
  logic       tsd_q;                 // overheat_shutdown
  logic       uv_q;                  // supply_under_volt
  logic       ov_q;                  // supply_over_volt

  // ==========================================================
  // Bus address phase capture
  logic       wr_q;                  // Pending write data phase
  logic [3:0] idx_q;                 // Index of the pending write
  logic       rd_sel;                // Read request accepted
  logic       wr_sel;                // Write request accepted
  logic [3:0] a_idx;                 // Address phase index

  assign a_idx  = i_haddr[5:2];
  assign rd_sel = i_hsel && i_hready && i_htrans[1] && !i_hwrite;
  assign wr_sel = i_hsel && i_hready && i_htrans[1] && i_hwrite;
  assign o_hreadyout = 1'b1;  // Zero wait states
  assign o_hresp     = 1'b0;  // Always OKAY

  // Write data phase strobes
  logic        wr_glob;
  logic        wr_en;
  logic [2:0]  wr_oc;    // One per overcurrent register
  logic [2:0]  wr_ol;    // One per open-load register
  logic [31:0] wdat;

  assign wdat    = i_hwdata;
  assign wr_glob = wr_q && (idx_q == hbfm_pkg::IDX_GLOBAL);
  assign wr_en   = wr_q && (idx_q == hbfm_pkg::IDX_ENABLE);

  // Clear masks: write 1 to clear, ten bits per kind
  logic [9:0] clr_hoc, clr_loc, clr_hol, clr_lol;

  // ==========================================================
  // Pack four bridges of high/low bits into one register word
  function automatic logic [31:0] pack(input logic [9:0] hi,
                                       input logic [9:0] lo,
                                       input int         grp);
    logic [31:0] w;
    int          b;
    w = hbfm_pkg::RESET_WORD;
    for (int k = 0; k < hbfm_pkg::BRIDGES_PER_REG; k++) begin
      b = grp * hbfm_pkg::BRIDGES_PER_REG + k;
      if (b < hbfm_pkg::NUM_BRIDGES) begin
        w[2*k]   = hi[b];
        w[2*k+1] = lo[b];
      end
    end
    return w;
  endfunction

  // Unpack a write word into per-bridge clear masks
  function automatic logic [9:0] unpack(input logic [31:0] w,
                                        input logic [2:0]  sel,
                                        input int          side);
    logic [9:0] m;
    int         g;
    m = 10'h000;
    for (int b = 0; b < hbfm_pkg::NUM_BRIDGES; b++) begin
      g = b / hbfm_pkg::BRIDGES_PER_REG;
      m[b] = sel[g] && w[2*(b % hbfm_pkg::BRIDGES_PER_REG) + side];
    end
    return m;
  endfunction

  genvar r;
  generate
    for (r = 0; r < 3; r++) begin : g_strobe
      assign wr_oc[r] = wr_q &&
        (idx_q == 4'(hbfm_pkg::IDX_OC_FIRST + r));
      assign wr_ol[r] = wr_q &&
        (idx_q == 4'(hbfm_pkg::IDX_OL_FIRST + r));
    end
  endgenerate

  assign clr_hoc = unpack(wdat, wr_oc, 0);
  assign clr_loc = unpack(wdat, wr_oc, 1);
  assign clr_hol = unpack(wdat, wr_ol, 0);
  assign clr_lol = unpack(wdat, wr_ol, 1);

  // ==========================================================
  // Bridge legs
  logic [9:0] hoc_ev, loc_ev, hol_ev, lol_ev;  // Filter expiry
  logic       global_off;                      // All stages Hi-Z
  logic       supply_bad;                      // Live supply fault

  assign supply_bad = i_supply_under || i_supply_over;
  assign global_off = tsd_q || supply_bad;

  genvar n;
  generate
    for (n = 0; n < hbfm_pkg::NUM_BRIDGES; n++) begin : g_leg
      hbfm_leg_if lif ();
      // Enables are never touched by faults; gating is separate
      assign lif.hi_req = high_switch_enable_q[n] && !global_off &&
                          !high_switch_overcurrent_q[n];
      assign lif.lo_req = low_switch_enable_q[n] && !global_off &&
                          !low_switch_overcurrent_q[n];
      assign lif.hi_meas  = i_high_over_i[n];
      assign lif.lo_meas  = i_low_over_i[n];
      assign lif.hi_low_i = i_high_under_i[n];
      assign lif.lo_low_i = i_low_under_i[n];
      hbfm_leg u_leg (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_ce      (i_ce),
        .leg       (lif.leg)
      );
      assign o_high_gate[n] = lif.hi_drive;
      assign o_low_gate[n]  = lif.lo_drive;
      assign hoc_ev[n] = lif.hi_oc;
      assign loc_ev[n] = lif.lo_oc;
      assign hol_ev[n] = lif.hi_ol;
      assign lol_ev[n] = lif.lo_ol;
    end
  endgenerate

  // ==========================================================
  // Next values of sticky bits: set wins over clear
  logic [9:0] hoc_d, loc_d, hol_d, lol_d;
  logic       warn_d, tsd_d, uv_d, ov_d;
  logic       load_fault;  // global_load_fault, derived

  assign hoc_d = (high_switch_overcurrent_q & ~clr_hoc) | hoc_ev;
  assign loc_d = (low_switch_overcurrent_q & ~clr_loc) | loc_ev;
  assign hol_d = (high_switch_open_load_q & ~clr_hol) | hol_ev;
  assign lol_d = (low_switch_open_load_q & ~clr_lol) | lol_ev;
  assign warn_d = (warn_q && !(wr_glob && wdat[hbfm_pkg::BIT_WARN]))
                  || i_overheat_warn;
  assign tsd_d  = (tsd_q && !(wr_glob && wdat[hbfm_pkg::BIT_TSD]))
                  || i_overheat_trip;
  assign uv_d   = (uv_q && !(wr_glob && wdat[hbfm_pkg::BIT_UV]))
                  || i_supply_under;
  assign ov_d   = (ov_q && !(wr_glob && wdat[hbfm_pkg::BIT_OV]))
                  || i_supply_over;

  // Load fault follows latched per-switch bits, so it is 0
  // during filtering and rises with the first latch
  assign load_fault = |{high_switch_overcurrent_q,
                        low_switch_overcurrent_q,
                        high_switch_open_load_q,
                        low_switch_open_load_q};

  // Status registers: cleared only by host writes
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      high_switch_overcurrent_q <= 10'h000;
      low_switch_overcurrent_q  <= 10'h000;
      high_switch_open_load_q   <= 10'h000;
      low_switch_open_load_q    <= 10'h000;
      warn_q <= 1'b0;
      tsd_q  <= 1'b0;
      uv_q   <= 1'b0;
      ov_q   <= 1'b0;
    end else if (i_ce) begin
      high_switch_overcurrent_q <= hoc_d;
      low_switch_overcurrent_q  <= loc_d;
      high_switch_open_load_q   <= hol_d;
      low_switch_open_load_q    <= lol_d;
      warn_q <= warn_d;
      tsd_q  <= tsd_d;
      uv_q   <= uv_d;
      ov_q   <= ov_d;
    end
  end

  // Enable register, written only by the host
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      high_switch_enable_q <= 10'h000;
      low_switch_enable_q  <= 10'h000;
    end else if (i_ce && wr_en) begin
      high_switch_enable_q <= wdat[9:0];
      low_switch_enable_q  <= wdat[25:16];
    end
  end

  // ==========================================================
  // Read data selection
  logic [31:0] glob_word, rd_word;
  always_comb begin
    glob_word = hbfm_pkg::RESET_WORD;
    glob_word[hbfm_pkg::BIT_WARN] = warn_q;
    glob_word[hbfm_pkg::BIT_TSD]  = tsd_q;
    glob_word[hbfm_pkg::BIT_OV]   = ov_q;
    glob_word[hbfm_pkg::BIT_UV]   = uv_q;
    glob_word[hbfm_pkg::BIT_LOAD] = load_fault;
  end

  always_comb begin
    if (a_idx == hbfm_pkg::IDX_GLOBAL) begin
      rd_word = glob_word;
    end else if (a_idx >= hbfm_pkg::IDX_OC_FIRST &&
                 a_idx < hbfm_pkg::IDX_OL_FIRST) begin
      rd_word = pack(high_switch_overcurrent_q, low_switch_overcurrent_q,
                     int'(a_idx - hbfm_pkg::IDX_OC_FIRST));
    end else if (a_idx >= hbfm_pkg::IDX_OL_FIRST &&
                 a_idx < hbfm_pkg::IDX_ENABLE) begin
      rd_word = pack(high_switch_open_load_q, low_switch_open_load_q,
                     int'(a_idx - hbfm_pkg::IDX_OL_FIRST));
    end else if (a_idx == hbfm_pkg::IDX_ENABLE) begin
      rd_word = {6'h00, low_switch_enable_q, 6'h00, high_switch_enable_q};
    end else if (a_idx == hbfm_pkg::IDX_LIVE) begin
      rd_word = {6'h00, o_low_gate, 6'h00, o_high_gate};
    end else begin
      rd_word = hbfm_pkg::RESET_WORD;  // Unmapped reads zero
    end
  end

  // Bus phase registers and read data
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      wr_q     <= 1'b0;
      idx_q    <= 4'h0;
      o_hrdata <= hbfm_pkg::RESET_WORD;
    end else if (i_ce) begin
      wr_q <= wr_sel;
      if (wr_sel) begin
        idx_q <= a_idx;
      end
      if (rd_sel) begin
        o_hrdata <= rd_word;
      end
    end
  end

endmodule

// *** dv/hbfm_host.sv ***
// Host model: AHB-Lite master issuing single word transfers.
// Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/10ps
module hbfm_host (
  // Bus clock and handshake
  input  wire logic        i_clk,
  input  wire logic        i_hready,
  input  wire logic [31:0] i_hrdata,
  // Master outputs
  output logic             o_hsel,
  output logic      [31:0] o_haddr,
  output logic      [1:0]  o_htrans,
  output logic             o_hwrite,
  output logic      [31:0] o_hwdata
);
  // Idle bus at time zero
  initial begin
    o_hsel   = 1'b0;
    o_haddr  = 32'h0000_0000;
    o_htrans = 2'b00;
    o_hwrite = 1'b0;
    o_hwdata = 32'h0000_0000;
  end

  // ==========================================================
  // One transfer; clearing writes carry ones at error bits
  task automatic xfer(input logic w, input logic [3:0] idx,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge i_clk);
    o_hsel   <= 1'b1;
    o_htrans <= 2'b10;
    o_hwrite <= w;
    o_haddr  <= {26'h000_0000, idx, 2'b00};
    do @(posedge i_clk); while (i_hready !== 1'b1);
    o_hsel   <= 1'b0;
    o_htrans <= 2'b00;
    o_hwdata <= wd;
    do @(posedge i_clk); while (i_hready !== 1'b1);
    rd = i_hrdata;
  endtask
endmodule

// *** dv/hbfm_top_chk.sv ***
// Checker of gate safety and bus response at the top ports.
// Assumes bind to hbfm_top with the clock enable held high.
`timescale 1ns/10ps
module hbfm_top_chk (
  // Clock and reset
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  // Monitors
  input wire logic [9:0] i_high_over_i,
  input wire logic       i_overheat_trip,
  input wire logic       i_supply_under,
  input wire logic       i_supply_over,
  // Outputs watched
  input wire logic       o_hreadyout,
  input wire logic       o_hresp,
  input wire logic [9:0] o_high_gate,
  input wire logic [9:0] o_low_gate
);
  localparam int OC_MAX = hbfm_pkg::OC_FILTER_CYC + 4;
  int oc_run_q;  // Cycles bridge 0 high drives into overcurrent

  // ==========================================================
  // Helper counter, restarts whenever the condition breaks
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !(o_high_gate[0] && i_high_over_i[0])) begin
      oc_run_q <= 0;
    end else begin
      oc_run_q <= oc_run_q + 1;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  // ==========================================================
  // Properties
  property p_bus_ok;
    o_hreadyout && !o_hresp;
  endproperty
  a_bus_ok: assert property (p_bus_ok)
    else $error("bus response not ready or not okay");
  property p_no_cross;
    (o_high_gate & o_low_gate) == 10'h000;
  endproperty
  a_no_cross: assert property (p_no_cross)
    else $error("both gates of a bridge on");
  property p_dead_hl;
    $fell(o_high_gate[0]) |-> !o_low_gate[0] [*8];
  endproperty
  a_dead_hl: assert property (p_dead_hl)
    else $error("low gate on without dead time");
  property p_dead_lh;
    $fell(o_low_gate[0]) |-> !o_high_gate[0] [*8];
  endproperty
  a_dead_lh: assert property (p_dead_lh)
    else $error("high gate on without dead time");
  property p_oc_trip;
    oc_run_q <= OC_MAX;
  endproperty
  a_oc_trip: assert property (p_oc_trip)
    else $error("overcurrent switch not shut down");
  property p_uv_off;
    i_supply_under [*3] |-> (o_high_gate | o_low_gate) == 10'h000;
  endproperty
  a_uv_off: assert property (p_uv_off)
    else $error("gate on during undervoltage");
  property p_ov_off;
    i_supply_over [*3] |-> (o_high_gate | o_low_gate) == 10'h000;
  endproperty
  a_ov_off: assert property (p_ov_off)
    else $error("gate on during overvoltage");
  property p_tsd_off;
    i_overheat_trip [*3] |-> (o_high_gate | o_low_gate) == 10'h000;
  endproperty
  a_tsd_off: assert property (p_tsd_off)
    else $error("gate on during overheat trip");
endmodule

bind hbfm_top hbfm_top_chk u_chk (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_high_over_i(i_high_over_i),
  .i_overheat_trip(i_overheat_trip), .i_supply_under(i_supply_under),
  .i_supply_over(i_supply_over), .o_hreadyout(o_hreadyout),
  .o_hresp(o_hresp), .o_high_gate(o_high_gate), .o_low_gate(o_low_gate)
);

// *** dv/test_hbfm_top.sv ***
// Self-checking bench for the fault manager top.
// Assumes the host model drives the bus; clock enable held high.
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  fails++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module test_hbfm_top;
  logic        i_clk     = 1'b0;
  logic        i_reset_n = 1'b0;
  logic [9:0]  hi_ov = '0, lo_ov = '0, hi_un = '0, lo_un = '0;
  logic [3:0]  gf    = 4'h0;  // Warn, trip, under, over
  logic        hsel, hwrite, hrdy, hresp;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [9:0]  hg, lg;
  int          fails = 0, samples_checked = 0, cyc = 0, n;

  always #4 i_clk = ~i_clk;  // 125 MHz

  hbfm_top dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_ce(1'b1),
    .i_high_over_i(hi_ov), .i_low_over_i(lo_ov), .i_high_under_i(hi_un),
    .i_low_under_i(lo_un), .i_overheat_warn(gf[0]),
    .i_overheat_trip(gf[1]), .i_supply_under(gf[2]),
    .i_supply_over(gf[3]), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'b010),
    .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
    .o_hreadyout(hrdy), .o_hresp(hresp), .o_high_gate(hg),
    .o_low_gate(lg));
  hbfm_host u_host (.i_clk(i_clk), .i_hready(hrdy), .i_hrdata(hrdata),
    .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans),
    .o_hwrite(hwrite), .o_hwdata(hwdata));

  // ==========================================================
  // Hang guard
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fails++;
      end_of_test();
    end
  end

  // ==========================================================
  // Shared helpers
  task automatic end_of_test;
    $display("checked %0d failed %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] i, input logic [31:0] d);
    u_host.xfer(1'b1, i, d, rd);
  endtask
  task automatic chk_rd(input logic [3:0] i, input logic [31:0] e);
    u_host.xfer(1'b0, i, 32'h0000_0000, rd);
    `CHK(rd, e)
  endtask
  function automatic logic gate(input int b, input int s);
    return s ? lg[b] : hg[b];
  endfunction
  // Wait, bounded, for a gate to reach a level; n counts cycles
  task automatic wait_gate(input int b, input int s, input logic v);
    n = 0;
    do begin
      @(posedge i_clk);
      #1;
      n++;
    end while (gate(b, s) !== v && n < 3000);
  endtask
  task automatic set_oc(input int b, input int s, input logic v);
    @(posedge i_clk);
    if (s) lo_ov[b] <= v;
    else hi_ov[b] <= v;
  endtask

  // ==========================================================
  // Scenarios
  task automatic reg_test;
    for (int i = 0; i < 16; i++) chk_rd(4'(i), 32'h0000_0000);
    wr(4'h1, 32'hffff_ffff);
    chk_rd(4'h1, 32'h0000_0000);
  endtask
  task automatic oc_case(input int b, input int s);
    logic [3:0]  ri;
    logic [31:0] m;
    logic [31:0] en;
    ri = 4'(2 + b / 4);
    m  = 32'h0000_0001 << (2 * (b % 4) + s);
    en = 32'h0000_0001 << (16 * s + b);
    wr(4'h8, en);
    wait_gate(b, s, 1'b1);
    set_oc(b, s, 1'b1);
    repeat (1200) @(posedge i_clk);
    chk_rd(ri, 32'h0000_0000);
    chk_rd(4'h0, 32'h0000_0000);
    `CHK(gate(b, s), 1'b1)
    wait_gate(b, s, 1'b0);
    `CHK(n < 60, 1'b1)
    chk_rd(ri, m);
    chk_rd(4'h0, 32'h0000_0040);
    chk_rd(4'h8, en);
    wr(ri, m);
    wait_gate(b, s, 1'b1);
    wait_gate(b, s, 1'b0);
    chk_rd(ri, m);
    set_oc(b, s, 1'b0);
    repeat (600) @(posedge i_clk);
    #1;
    `CHK(gate(b, s), 1'b0)
    wr(ri, m);
    wait_gate(b, s, 1'b1);
    `CHK(gate(b, s), 1'b1)
    wr(4'h8, 32'h0000_0000);
    wait_gate(b, s, 1'b0);
  endtask
  task automatic ol_test;
    // High side of bridge 5 and low side of bridge 6 run; the idle
    // high side of bridge 6 sees low current but must not flag
    wr(4'h8, 32'h0040_0020);
    wait_gate(6, 1, 1'b1);
    @(posedge i_clk);
    lo_un[6] <= 1'b1;
    hi_un[5] <= 1'b1;
    hi_un[6] <= 1'b1;
    repeat (2400) @(posedge i_clk);
    chk_rd(4'h6, 32'h0000_0000);
    repeat (200) @(posedge i_clk);
    chk_rd(4'h6, 32'h0000_0024);
    chk_rd(4'h0, 32'h0000_0040);
    `CHK(lg[6], 1'b1)
    `CHK(hg[5], 1'b1)
    @(posedge i_clk);
    lo_un[6] <= 1'b0;
    hi_un[5] <= 1'b0;
    hi_un[6] <= 1'b0;
    wr(4'h6, 32'h0000_0024);
    chk_rd(4'h0, 32'h0000_0000);
    wr(4'h8, 32'h0000_0000);
  endtask
  task automatic glob_test;
    logic [31:0] m;
    wr(4'h8, 32'h0000_0001);
    wait_gate(0, 0, 1'b1);
    for (int k = 0; k < 4; k++) begin
      m = 32'h0000_0001 << ((k == 0) ? 1 : (k == 1) ? 2 : (k == 2) ? 5 : 4);
      @(posedge i_clk);
      gf[k] <= 1'b1;
      repeat (10) @(posedge i_clk);
      #1;
      `CHK(hg[0], 1'(k == 0))
      @(posedge i_clk);
      gf[k] <= 1'b0;
      chk_rd(4'h0, m);
      repeat (700) @(posedge i_clk);
      #1;
      `CHK(hg[0], 1'(k != 1))
      chk_rd(4'h0, m);
      wr(4'h0, m);
      wait_gate(0, 0, 1'b1);
      chk_rd(4'h0, 32'h0000_0000);
    end
  endtask
  task automatic dead_test;
    wr(4'h8, 32'h0001_0000);
    wait_gate(0, 0, 1'b0);
    wait_gate(0, 1, 1'b1);
    `CHK(n >= hbfm_pkg::DEAD_HL_CYC - 1, 1'b1)
    wr(4'h8, 32'h0000_0001);
    wait_gate(0, 1, 1'b0);
    wait_gate(0, 0, 1'b1);
    `CHK(n >= hbfm_pkg::DEAD_LH_CYC - 1, 1'b1)
    wr(4'h8, 32'h0000_0000);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'b1;
    reg_test();
    oc_case(0, 0);
    oc_case(9, 1);
    ol_test();
    glob_test();
    dead_test();
    end_of_test();
  end
endmodule
